/* rtl/ssp_pkg.sv */
package ssp_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] SSP_CFG_ADDR = 8'hA1;
    localparam logic [7:0] SSP_CKR_ADDR = 8'hA2;
    localparam logic [7:0] SSP_DAT_ADDR = 8'hA3;
    localparam logic [7:0] SSP_CTL_ADDR = 8'hF8;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int SSP_CFG_MASTER_POS = 6;
    localparam int SSP_CFG_PHASE_POS = 5;
    localparam int SSP_CFG_POLARITY_POS = 4;
    localparam logic [1:0] SSP_SEL_3WIRE = 2'h0;
    localparam logic [1:0] SSP_SEL_4WIRE_SLAVE = 2'h1;
    localparam logic [1:0] SSP_SEL_MODE_RESET = 2'h1;
    localparam logic [7:0] SSP_CKR_RESET = 8'h00;
    localparam logic [7:0] SSP_BYTE_RESET = 8'h00;
    localparam logic [2:0] SSP_LAST_BIT = 3'h7;
    localparam logic [2:0] SSP_COUNT_RESET = 3'h0;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ssp_bus_req_type;

    // bit order matches the control register, msb first
    typedef struct packed {
        logic transfer_done_flag;
        logic write_collision_flag;
        logic mode_fault_flag;
        logic receive_overrun_flag;
        logic select_mode_high_bit;
        logic select_mode_low_bit;
        logic port_enable_bit;
    } ssp_ctrl_type;

    typedef struct packed {
        logic master_enable_bit;
        logic clock_phase_bit;
        logic clock_polarity_bit;
    } ssp_cfg_type;

endpackage : ssp_pkg

/* rtl/ssp_slave_port.sv */
`timescale 1ns/100ps
// Behaviour
// - enabled, not master and in select mode 00 or 01, the port shifts as a slave under SCK.
// - bit counter counts SCK edges; after eight bits set done, store byte.
// - slave never starts a transfer; data writes preload outgoing byte.
// - writes fill tx buffer; moved at once if shifter empty, else at end.
// - select mode 01 (default) is 4-wire slave with select pin as input.
// - in 4-wire mode slave logic active only while select is low.
// - in 4-wire mode the bit counter clears on each select falling edge.
// - select mode 00 is 3-wire slave; the only slave on the bus.
// - in 3-wire mode counter clears only by toggling port enable.
// - four flags request attention when set; only software clears them.
// - transfer-done flag, control bit 7, set at end of every byte.
// - data write while tx buffer full sets collision flag, write dropped.
// - master in multi-master mode, select falls: mode fault, disable port.
// - byte done while receive buffer unread: overrun flag, new byte lost.
// - config bit 5 picks latching edge, bit 4 picks SCK idle polarity.
// - clock divider is only stored and read back; no SCK is generated from it.
// - master bit rate never above half system clock or 12.5 MHz.
// - MISO released while disabled or unselected 4-wire; SCK ignored then.
// - as 3-wire slave MISO always shows shift register msb.
// - both data lines carry most significant bit first.
module ssp_slave_port
    import ssp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire ssp_bus_req_type bus_req,
    output logic [7:0] bus_rdata,
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic nss_i,
    output logic nss_o,
    output logic nss_oe,
    output logic miso_o,
    output logic miso_oe,
    output logic flags_pending
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] pin_meta_r;
    logic [2:0] pin_sync_r;
    logic [2:0] pin_prev_r;
    logic [2:0] pin_meta_nxt;
    logic [2:0] pin_sync_nxt;
    logic [2:0] pin_prev_nxt;

    always_comb begin
        pin_meta_nxt = {sck_i, mosi_i, nss_i};
        pin_sync_nxt = pin_meta_r;
        pin_prev_nxt = pin_sync_r;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_meta_r <= 3'h1;
            pin_sync_r <= 3'h1;
            pin_prev_r <= 3'h1;
        end else begin
            pin_meta_r <= pin_meta_nxt;
            pin_sync_r <= pin_sync_nxt;
            pin_prev_r <= pin_prev_nxt;
        end
    end

    // ------------------------------------------------------------------
    // port state
    // ------------------------------------------------------------------
    ssp_ctrl_type ctrl_r;
    ssp_ctrl_type ctrl_nxt;
    ssp_cfg_type cfg_r;
    ssp_cfg_type cfg_nxt;
    logic [7:0] ckr_r;
    logic [7:0] ckr_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [7:0] txbuf_r;
    logic [7:0] txbuf_nxt;
    logic [7:0] rxbuf_r;
    logic [7:0] rxbuf_nxt;
    logic [2:0] count_r;
    logic [2:0] count_nxt;
    logic bit_r;
    logic bit_nxt;
    logic pending_r;
    logic pending_nxt;
    logic tx_full_r;
    logic tx_full_nxt;
    logic rx_full_r;
    logic rx_full_nxt;
    logic shift_empty_r;
    logic shift_empty_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic flags_r;
    logic flags_nxt;

    logic sck_s;
    logic sck_p;
    logic mosi_s;
    logic nss_s;
    logic nss_fall;
    logic lead_edge;
    logic trail_edge;
    logic sample_edge;
    logic shift_edge;
    logic three_wire;
    logic four_wire;
    logic slave_on;
    logic selected;
    logic [7:0] rx_byte;

    assign sck_s = pin_sync_r[2];
    assign mosi_s = pin_sync_r[1];
    assign nss_s = pin_sync_r[0];
    assign sck_p = pin_prev_r[2];
    assign nss_fall = pin_prev_r[0] & ~nss_s;

    // idle level removed first, so one edge pair serves both polarities
    assign lead_edge = ~(sck_p ^ cfg_r.clock_polarity_bit)
        & (sck_s ^ cfg_r.clock_polarity_bit);
    assign trail_edge = (sck_p ^ cfg_r.clock_polarity_bit)
        & ~(sck_s ^ cfg_r.clock_polarity_bit);

    assign three_wire = ({ctrl_r.select_mode_high_bit,
        ctrl_r.select_mode_low_bit} == SSP_SEL_3WIRE);
    assign four_wire = ({ctrl_r.select_mode_high_bit,
        ctrl_r.select_mode_low_bit} == SSP_SEL_4WIRE_SLAVE);
    assign slave_on = ctrl_r.port_enable_bit
        & ~cfg_r.master_enable_bit;
    assign selected = slave_on
        & (three_wire | (four_wire & ~nss_s));

    // phase picks which edge latches; the other edge moves the shifter
    assign sample_edge = selected
        & (cfg_r.clock_phase_bit ? trail_edge : lead_edge);
    assign shift_edge = selected
        & (cfg_r.clock_phase_bit ? lead_edge : trail_edge);

    assign rx_byte = {shift_r[6:0], mosi_s};

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_nxt = ctrl_r;
        cfg_nxt = cfg_r;
        ckr_nxt = ckr_r;
        shift_nxt = shift_r;
        txbuf_nxt = txbuf_r;
        rxbuf_nxt = rxbuf_r;
        count_nxt = count_r;
        bit_nxt = bit_r;
        pending_nxt = pending_r;
        tx_full_nxt = tx_full_r;
        rx_full_nxt = rx_full_r;
        shift_empty_nxt = shift_empty_r;
        rdata_nxt = 8'h00;

        // software writes: flags may only be cleared, the set below wins
        if (bus_req.wr) begin
            case (bus_req.addr)
                SSP_CTL_ADDR: begin
                    ctrl_nxt.transfer_done_flag =
                        ctrl_r.transfer_done_flag & bus_req.wdata[7];
                    ctrl_nxt.write_collision_flag =
                        ctrl_r.write_collision_flag & bus_req.wdata[6];
                    ctrl_nxt.mode_fault_flag =
                        ctrl_r.mode_fault_flag & bus_req.wdata[5];
                    ctrl_nxt.receive_overrun_flag =
                        ctrl_r.receive_overrun_flag & bus_req.wdata[4];
                    ctrl_nxt.select_mode_high_bit = bus_req.wdata[3];
                    ctrl_nxt.select_mode_low_bit = bus_req.wdata[2];
                    ctrl_nxt.port_enable_bit = bus_req.wdata[0];
                end
                SSP_CFG_ADDR: begin
                    cfg_nxt.master_enable_bit =
                        bus_req.wdata[SSP_CFG_MASTER_POS];
                    cfg_nxt.clock_phase_bit =
                        bus_req.wdata[SSP_CFG_PHASE_POS];
                    cfg_nxt.clock_polarity_bit =
                        bus_req.wdata[SSP_CFG_POLARITY_POS];
                end
                // stored for software only; no master clock is generated,
                // so no master bit rate exists to exceed any limit
                SSP_CKR_ADDR: ckr_nxt = bus_req.wdata;
                SSP_DAT_ADDR: begin
                    if (tx_full_r) begin
                        ctrl_nxt.write_collision_flag = 1'b1;
                    end else if (shift_empty_r) begin
                        shift_nxt = bus_req.wdata;
                        shift_empty_nxt = 1'b0;
                    end else begin
                        txbuf_nxt = bus_req.wdata;
                        tx_full_nxt = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // register reads; reading the data window frees the receive buffer
        if (bus_req.rd) begin
            case (bus_req.addr)
                SSP_CTL_ADDR: rdata_nxt = {ctrl_r.transfer_done_flag,
                    ctrl_r.write_collision_flag, ctrl_r.mode_fault_flag,
                    ctrl_r.receive_overrun_flag, ctrl_r.select_mode_high_bit,
                    ctrl_r.select_mode_low_bit, ~tx_full_r,
                    ctrl_r.port_enable_bit};
                SSP_CFG_ADDR: rdata_nxt = {(count_r != SSP_COUNT_RESET)
                    | pending_r, cfg_r.master_enable_bit,
                    cfg_r.clock_phase_bit, cfg_r.clock_polarity_bit,
                    ~nss_s & four_wire, nss_s,
                    shift_empty_r | cfg_r.master_enable_bit,
                    ~rx_full_r | cfg_r.master_enable_bit};
                SSP_CKR_ADDR: rdata_nxt = ckr_r;
                SSP_DAT_ADDR: begin
                    rdata_nxt = rxbuf_r;
                    rx_full_nxt = 1'b0;
                end
                default: rdata_nxt = 8'h00;
            endcase
        end

        // any edge of a started byte means the shifter is no longer idle
        if (sample_edge | shift_edge) begin
            shift_empty_nxt = 1'b0;
        end

        if (shift_edge && pending_r) begin
            shift_nxt = {shift_r[6:0], bit_r};
            pending_nxt = 1'b0;
        end

        if (sample_edge) begin
            if (count_r == SSP_LAST_BIT) begin
                count_nxt = SSP_COUNT_RESET;
                pending_nxt = 1'b0;
                ctrl_nxt.transfer_done_flag = 1'b1;
                if (rx_full_r
                    && !(bus_req.rd && bus_req.addr == SSP_DAT_ADDR)) begin
                    ctrl_nxt.receive_overrun_flag = 1'b1;
                end else begin
                    rxbuf_nxt = rx_byte;
                    rx_full_nxt = 1'b1;
                end
                if (tx_full_r) begin
                    shift_nxt = txbuf_r;
                    tx_full_nxt = 1'b0;
                    shift_empty_nxt = 1'b0;
                end else begin
                    shift_nxt = rx_byte;
                    shift_empty_nxt = 1'b1;
                end
            end else begin
                count_nxt = count_r + 3'h1;
                bit_nxt = mosi_s;
                pending_nxt = 1'b1;
            end
        end

        // select falling edge restarts the byte in 4-wire mode
        if (four_wire && nss_fall) begin
            count_nxt = SSP_COUNT_RESET;
            pending_nxt = 1'b0;
        end

        // a disabled port holds its counter clear; the only 3-wire reset
        if (!ctrl_r.port_enable_bit) begin
            count_nxt = SSP_COUNT_RESET;
            pending_nxt = 1'b0;
        end

        // another master took the bus: stand down at once
        if (cfg_r.master_enable_bit && ctrl_r.port_enable_bit
            && four_wire && nss_fall) begin
            ctrl_nxt.mode_fault_flag = 1'b1;
            ctrl_nxt.port_enable_bit = 1'b0;
            cfg_nxt.master_enable_bit = 1'b0;
        end

        flags_nxt = ctrl_nxt.transfer_done_flag
            | ctrl_nxt.write_collision_flag
            | ctrl_nxt.mode_fault_flag
            | ctrl_nxt.receive_overrun_flag;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_r <= '{1'b0, 1'b0, 1'b0, 1'b0, SSP_SEL_MODE_RESET[1],
                SSP_SEL_MODE_RESET[0], 1'b0};
            cfg_r <= '{1'b0, 1'b0, 1'b0};
            ckr_r <= SSP_CKR_RESET;
            shift_r <= SSP_BYTE_RESET;
            txbuf_r <= SSP_BYTE_RESET;
            rxbuf_r <= SSP_BYTE_RESET;
            count_r <= SSP_COUNT_RESET;
            bit_r <= 1'b0;
            pending_r <= 1'b0;
            tx_full_r <= 1'b0;
            rx_full_r <= 1'b0;
            shift_empty_r <= 1'b1;
            rdata_r <= 8'h00;
            flags_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            cfg_r <= cfg_nxt;
            ckr_r <= ckr_nxt;
            shift_r <= shift_nxt;
            txbuf_r <= txbuf_nxt;
            rxbuf_r <= rxbuf_nxt;
            count_r <= count_nxt;
            bit_r <= bit_nxt;
            pending_r <= pending_nxt;
            tx_full_r <= tx_full_nxt;
            rx_full_r <= rx_full_nxt;
            shift_empty_r <= shift_empty_nxt;
            rdata_r <= rdata_nxt;
            flags_r <= flags_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign bus_rdata = rdata_r;
    assign flags_pending = flags_r;
    assign miso_o = shift_r[7];
    assign miso_oe = selected;
    // select driven out in select modes 10 and 11 while the port is enabled
    assign nss_o = ctrl_r.select_mode_low_bit;
    assign nss_oe = ctrl_r.select_mode_high_bit & ctrl_r.port_enable_bit;

endmodule : ssp_slave_port

/* testbench/ssp_mst.sv */
`timescale 1ns/100ps
module ssp_mst (
    input wire logic clk,
    output logic sck,
    output logic mosi,
    output logic nss_n,
    input wire logic miso,
    input wire logic [3:0] half
);
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        nss_n = 1'b1;
    end
    // nbits of tx msb first; sck stands still outside the frame
    task automatic xfer(input logic cpol, input logic cpha, input logic sel,
                        input int nbits, input logic [7:0] tx,
                        output logic [7:0] rx);
        rx = 8'h00;
        @(posedge clk);
        sck <= cpol;
        nss_n <= !sel;
        repeat (3) @(posedge clk); // select leads first edge
        for (int i = 7; i > 7 - nbits; i--) begin
            if (!cpha) mosi <= tx[i]; // msb first
            // half period 6 keeps under a tenth of clk
            repeat (half) @(posedge clk);
            sck <= ~cpol;
            if (cpha) mosi <= tx[i];
            else rx[i] = miso;
            repeat (half) @(posedge clk);
            sck <= cpol; // phase and polarity as the port
            if (cpha) rx[i] = miso;
        end
        repeat (6) @(posedge clk);
        nss_n <= 1'b1;
        mosi <= ~mosi; // released data shows no stale bit
    endtask : xfer
endmodule : ssp_mst

/* testbench/ssp_slave_port_chk.sv */
`timescale 1ns/100ps
module ssp_slave_port_chk
    import ssp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire ssp_bus_req_type bus_req,
    input wire logic [7:0] bus_rdata,
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic nss_i,
    input wire logic nss_o,
    input wire logic nss_oe,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic flags_pending
);
    logic ctl_wr;
    logic sck_r, nss_r;
    logic [3:0] quiet_r, quiet_nxt;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    assign ctl_wr = bus_req.wr && (bus_req.addr == SSP_CTL_ADDR);
    // cycles since the last sck or select move or bus write, saturating
    always_comb begin
        quiet_nxt = (quiet_r == 4'hF) ? quiet_r : quiet_r + 4'h1;
        if (sck_i != sck_r || nss_i != nss_r || bus_req.wr) begin
            quiet_nxt = 4'h0;
        end
    end
    always_ff @(posedge clk) begin
        sck_r <= sck_i;
        nss_r <= nss_i;
        quiet_r <= rst_n ? quiet_nxt : 4'hF;
    end
    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    AST_RDATA_IDLE: assert property (
        !bus_req.rd |=> bus_rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_MISO_QUIET: assert property (
        (!bus_req.wr && $stable(sck_i))[*6] |-> $stable(miso_o))
        else $error("miso moved without clock or write");
    AST_FLAG_CAUSE: assert property (
        $rose(flags_pending) |-> quiet_r < 4'h9)
        else $error("flag raised with no recent cause");
    AST_FLAG_STICKY: assert property (
        flags_pending && !ctl_wr && !$past(ctl_wr) |=> flags_pending)
        else $error("flag dropped without software clear");
    AST_FLAG_CLEAR: assert property (
        $fell(flags_pending) |-> $past(ctl_wr) || $past(ctl_wr, 2))
        else $error("flag fell without a control write");
    AST_NSS_OE_CAUSE: assert property (
        $rose(nss_oe) |-> $past(ctl_wr) || $past(ctl_wr, 2))
        else $error("select driven without mode write");
    AST_NSS_O_CAUSE: assert property (
        $changed(nss_o) |-> $past(ctl_wr) || $past(ctl_wr, 2))
        else $error("select level moved without mode write");
    AST_MISO_OE_CAUSE: assert property (
        $rose(miso_oe) |-> $past(bus_req.wr) || $past(bus_req.wr, 2)
            || !$past(nss_i, 2))
        else $error("miso driven while not selected");
endmodule : ssp_slave_port_chk

bind ssp_slave_port ssp_slave_port_chk u_chk (.clk(clk), .rst_n(rst_n),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .sck_i(sck_i),
    .mosi_i(mosi_i), .nss_i(nss_i), .nss_o(nss_o), .nss_oe(nss_oe),
    .miso_o(miso_o), .miso_oe(miso_oe), .flags_pending(flags_pending));

/* testbench/tb.sv */
`timescale 1ns/100ps
module tb;
    import ssp_pkg::*;
    logic clk, rst_n, sck, mosi, nss_n, nss_o, nss_oe, miso_o, miso_oe;
    logic flags_pending, miso_last, miso_w;
    ssp_bus_req_type bus_req;
    logic [7:0] bus_rdata, got, mb, rx;
    logic [1:0] mode;
    logic [3:0] half;
    int n_errors, compares;

    ssp_slave_port uut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .sck_i(sck), .mosi_i(mosi), .nss_i(nss_n),
        .nss_o(nss_o), .nss_oe(nss_oe), .miso_o(miso_o),
        .miso_oe(miso_oe), .flags_pending(flags_pending));
    ssp_mst mst (.clk(clk), .sck(sck), .mosi(mosi), .nss_n(nss_n),
        .miso(miso_w), .half(half));

    // released miso shows the inverse of its last driven bit
    assign miso_w = miso_oe ? miso_o : ~miso_last;
    always @(posedge clk) if (miso_oe) miso_last <= miso_o;
    always #10 clk = ~clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req <= '0;
        @(posedge clk);
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= '0;
        #1 check(bus_rdata, exp);
        @(posedge clk);
    endtask : rchk
    function automatic logic [7:0] ctl(input logic [3:0] fl,
        input logic [1:0] md, input logic txe, input logic en);
        return {fl, md, txe, en};
    endfunction : ctl
    task automatic results();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        results();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        bus_req = '0;
        miso_last = 1'b0;
        half = 4'h6;
        n_errors = 0;
        compares = 0;
        void'($urandom(32'hE989));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // ----------------------------------------------------------
        // reset values, divider and stream in three-wire mode
        // ----------------------------------------------------------
        rchk(SSP_CTL_ADDR, 8'h06);
        rchk(SSP_CFG_ADDR, 8'h07);
        mb = 8'($urandom);
        wr(SSP_CKR_ADDR, mb);
        rchk(SSP_CKR_ADDR, mb);
        rchk(8'h55, 8'h00);
        wr(SSP_CTL_ADDR, ctl(4'h0, SSP_SEL_3WIRE, 1'b0, 1'b1));
        wr(SSP_DAT_ADDR, 8'hA5);
        fork
            mst.xfer(1'b0, 1'b0, 1'b0, 8, 8'h3C, rx);
            begin
                repeat (40) @(posedge clk);
                wr(SSP_DAT_ADDR, 8'h5A);
            end
        join
        check(rx, 8'hA5);
        check({7'h00, flags_pending}, 8'h01);
        rchk(SSP_DAT_ADDR, 8'h3C);
        rchk(SSP_CTL_ADDR, ctl(4'h8, SSP_SEL_3WIRE, 1'b1, 1'b1));
        wr(SSP_CTL_ADDR, ctl(4'h0, SSP_SEL_3WIRE, 1'b0, 1'b1));
        check({7'h00, flags_pending}, 8'h00);
        fork
            mst.xfer(1'b0, 1'b0, 1'b0, 8, 8'h96, rx);
            begin
                repeat (40) @(posedge clk);
                wr(SSP_DAT_ADDR, 8'hC3);
                wr(SSP_DAT_ADDR, 8'h77);
            end
        join
        check(rx, 8'h5A);
        rchk(SSP_CTL_ADDR, ctl(4'hC, SSP_SEL_3WIRE, 1'b1, 1'b1));
        wr(SSP_CTL_ADDR, ctl(4'h0, SSP_SEL_3WIRE, 1'b0, 1'b1));
        mst.xfer(1'b0, 1'b0, 1'b0, 8, 8'hE1, rx);
        check(rx, 8'hC3);
        rchk(SSP_CTL_ADDR, ctl(4'h9, SSP_SEL_3WIRE, 1'b1, 1'b1));
        rchk(SSP_DAT_ADDR, 8'h96);
        mst.xfer(1'b0, 1'b0, 1'b0, 3, 8'hFF, rx);
        wr(SSP_CTL_ADDR, ctl(4'h0, SSP_SEL_3WIRE, 1'b0, 1'b0));
        wr(SSP_CTL_ADDR, ctl(4'h0, SSP_SEL_3WIRE, 1'b0, 1'b1));
        mb = 8'($urandom);
        mst.xfer(1'b0, 1'b0, 1'b0, 8, mb, rx);
        rchk(SSP_DAT_ADDR, mb);
        // receive-only byte at a quarter of the system clock
        half <= 4'h2;
        mb = 8'($urandom);
        mst.xfer(1'b0, 1'b0, 1'b0, 8, mb, rx);
        rchk(SSP_DAT_ADDR, mb);
        half <= 4'h6;
        // ----------------------------------------------------------
        // every phase and polarity in both select modes
        // ----------------------------------------------------------
        for (int m = 0; m < 8; m++) begin
            mode = m[2] ? SSP_SEL_4WIRE_SLAVE : SSP_SEL_3WIRE;
            wr(SSP_CTL_ADDR, ctl(4'h0, mode, 1'b0, 1'b0));
            wr(SSP_CFG_ADDR, {2'b00, m[1], m[0], 4'h0});
            mst.xfer(m[0], m[1], 1'b0, 0, 8'h00, rx);
            wr(SSP_CTL_ADDR, ctl(4'h0, mode, 1'b0, 1'b1));
            // with no data written the shifter echoes the last byte
            got = mb;
            mb = 8'($urandom);
            mst.xfer(m[0], m[1], m[2], 8, mb, rx);
            check(rx, got);
            rchk(SSP_DAT_ADDR, mb);
            rchk(SSP_CTL_ADDR, ctl(4'h8, mode, 1'b1, 1'b1));
        end
        // partial byte, unselected byte, then a framed byte
        wr(SSP_CTL_ADDR, ctl(4'h0, SSP_SEL_4WIRE_SLAVE, 1'b0, 1'b1));
        mst.xfer(1'b1, 1'b1, 1'b1, 3, 8'hFF, rx);
        mb = 8'($urandom);
        mst.xfer(1'b1, 1'b1, 1'b0, 8, mb, rx);
        mst.xfer(1'b1, 1'b1, 1'b1, 8, ~mb, rx);
        rchk(SSP_DAT_ADDR, ~mb);
        rchk(SSP_CTL_ADDR,
            ctl(4'h8, SSP_SEL_4WIRE_SLAVE, 1'b1, 1'b1));
        // ----------------------------------------------------------
        // mode fault and driven select
        // ----------------------------------------------------------
        wr(SSP_CTL_ADDR, ctl(4'h0, SSP_SEL_4WIRE_SLAVE, 1'b0, 1'b1));
        wr(SSP_CFG_ADDR, 8'h70);
        mst.xfer(1'b1, 1'b1, 1'b1, 0, 8'h00, rx);
        rchk(SSP_CTL_ADDR,
            ctl(4'h2, SSP_SEL_4WIRE_SLAVE, 1'b1, 1'b0));
        bus_req <= '{addr: SSP_CFG_ADDR, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= '0;
        #1 check(bus_rdata & 8'h40, 8'h00);
        @(posedge clk);
        wr(SSP_CTL_ADDR, ctl(4'h0, 2'h3, 1'b0, 1'b1));
        repeat (2) @(posedge clk);
        check({6'h00, nss_oe, nss_o}, 8'h03);
        wr(SSP_CTL_ADDR, ctl(4'h0, 2'h2, 1'b0, 1'b1));
        repeat (2) @(posedge clk);
        check({6'h00, nss_oe, nss_o}, 8'h02);
        results();
    end
endmodule : tb
